// ### hw/gtsw_defs.svh
// Constants of the gear tooth switch logic
`ifndef GTSW_DEFS_SVH
`define GTSW_DEFS_SVH
`define GTSW_SIG_W           12
`define GTSW_GAIN_W          4
`define GTSW_GAIN_RST        4'hf
`define GTSW_GAIN_MIN        4'h1
`define GTSW_STARTUP_HYS     12'h080
`define GTSW_VIB_LIMIT       12'h040
`define GTSW_OPT_LEVEL       12'h600
`define GTSW_OVR_LEVEL       12'h7f0
`define GTSW_CAL_PEAKS       3
`define GTSW_POWERUP_NS      1000
`define GTSW_CLK_MHZ         200
`define GTSW_POWERUP_CYC     ((`GTSW_POWERUP_NS * `GTSW_CLK_MHZ + 999) / 1000)
`define GTSW_GAIN_STEP_CYC   256
`define GTSW_WDOG_CYC        1000000
`define GTSW_OFS_SHIFT       6
`endif

// ### hw/gtsw_pkg.sv
// Types of the gear tooth switch logic
package gtsw_pkg;
	typedef enum logic [2:0] {
		GTSW_POWERUP = 3'b000,
		GTSW_STARTUP = 3'b001,
		GTSW_CAL     = 3'b010,
		GTSW_RUN     = 3'b011
	} gtsw_mode_e;
endpackage

// ### hw/gtsw_peak_track.sv
// Peak and valley tracker of the processed field signal
`timescale 1ns/1ps
`include "gtsw_defs.svh"
module gtsw_peak_track #(
	parameter int W = `GTSW_SIG_W
) (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         clk_en,
	input  wire logic         clear,
	input  wire logic         sample_vld,
	input  wire logic [W-1:0] sample,
	output logic      [W-1:0] peak_hi,
	output logic      [W-1:0] peak_lo,
	output logic      [W-1:0] p2p
);
	initial begin
		if (W < 4) $error("gtsw_peak_track: W too small");
	end

	logic [W-1:0] hi_r;
	logic [W-1:0] lo_r;
	logic [W-1:0] p2p_r;
	wire  [W-1:0] hi_nxt = (sample > hi_r) ? sample : hi_r;
	wire  [W-1:0] lo_nxt = (sample < lo_r) ? sample : lo_r;

	always_ff @(posedge sys_clk) begin
		if (srst || (clk_en && clear)) begin
			hi_r  <= '0;
			lo_r  <= '1;
			p2p_r <= '0;
		end else if (clk_en && sample_vld) begin
			hi_r  <= hi_nxt;
			lo_r  <= lo_nxt;
			p2p_r <= (hi_nxt > lo_nxt) ? hi_nxt - lo_nxt : '0;
		end
	end

	assign peak_hi = hi_r;
	assign peak_lo = lo_r;
	assign p2p     = p2p_r;
endmodule

// ### hw/gtsw_switch_logic.sv
// Decision logic of the two-wire gear tooth sensor
`timescale 1ns/1ps
`include "gtsw_defs.svh"
module gtsw_switch_logic #(
	parameter int W         = `GTSW_SIG_W,
	parameter int GW        = `GTSW_GAIN_W,
	parameter int CAL_PEAKS = `GTSW_CAL_PEAKS,
	parameter int WDOG_CYC  = `GTSW_WDOG_CYC
) (
	input  wire logic          sys_clk,
	input  wire logic          srst,
	input  wire logic          clk_en,
	input  wire logic          sample_vld,
	input  wire logic [W-1:0]  processed_field_signal,
	input  wire logic          undervoltage_level,
	output logic               supply_current_output,
	output logic [GW-1:0]      gain,
	output logic [W-1:0]       offset_tracker,
	output logic [2:0]         mode,
	output logic               vib_blank
);
	initial begin
		if (W < 8 || GW < 2 || CAL_PEAKS < 3 || WDOG_CYC < 16)
			$error("gtsw_switch_logic: unsupported parameters");
	end

	localparam int PU_CYC = `GTSW_POWERUP_CYC;
	localparam logic [W-1:0] HYS  = W'(`GTSW_STARTUP_HYS);
	localparam logic [W-1:0] VIB  = W'(`GTSW_VIB_LIMIT);
	localparam logic [W-1:0] OPT  = W'(`GTSW_OPT_LEVEL);
	localparam logic [W-1:0] OVR  = W'(`GTSW_OVR_LEVEL);
	localparam logic [W-1:0] MID  = W'(1) << (W - 1);

	function automatic logic [W-1:0] midpoint(input logic [W-1:0] a, input logic [W-1:0] b);
		logic [W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[W:1];
	endfunction

	gtsw_pkg::gtsw_mode_e mode_r;
	logic [31:0]  cnt_r;
	logic [31:0]  wdog_r;
	logic [15:0]  step_r;
	logic [7:0]   peaks_r;
	logic         out_r;
	logic [GW-1:0] gain_r;
	logic [W-1:0] ofs_r;
	logic [W-1:0] last_hi_r;
	logic [W-1:0] last_lo_r;
	logic [W-1:0] prev_r;
	logic         trk_clr;
	logic [W-1:0] pk_hi;
	logic [W-1:0] pk_lo;
	logic [W-1:0] p2p;

	// Offset correction is applied to every sample, so it covers all modes
	// The tracked offset is a deviation from mid-scale, so removing it re-centres the sample
	wire [W-1:0] sig      = processed_field_signal - ofs_r;
	wire         rising   = sig > prev_r;
	// Side of the start-up swing; a flat sample with drifting offset must not flip it
	wire         hi_side  = sig > midpoint(pk_hi, pk_lo);
	wire [W-1:0] thr      = midpoint(last_hi_r, last_lo_r);
	wire [W-1:0] hyst     = (last_hi_r - last_lo_r) >> 3;
	wire [W-1:0] op_thr   = thr + hyst;
	wire [W-1:0] rel_thr  = thr - hyst;
	wire         op_x     = (prev_r < op_thr) && (sig >= op_thr);
	wire         rel_x    = (prev_r > rel_thr) && (sig <= rel_thr);
	wire         start_ok = p2p > HYS;
	wire         running  = mode_r == gtsw_pkg::GTSW_RUN;
	wire         switching = mode_r == gtsw_pkg::GTSW_CAL || running;
	wire         vib      = running && ((last_hi_r - last_lo_r) < VIB);
	wire         edge_evt = switching && sample_vld && (op_x || rel_x) && !vib;
	wire         wdog_hit = switching && (wdog_r >= 32'(WDOG_CYC));
	wire [W-1:0] sig_abs  = sig >= MID ? sig - MID : MID - sig;

	gtsw_peak_track #(
		.W          (W)
	) u_track (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.clk_en     (clk_en),
		.clear      (trk_clr),
		.sample_vld (sample_vld),
		.sample     (sig),
		.peak_hi    (pk_hi),
		.peak_lo    (pk_lo),
		.p2p        (p2p)
	);

	assign trk_clr = wdog_hit || (mode_r == gtsw_pkg::GTSW_POWERUP);

	always_ff @(posedge sys_clk) begin
		if (srst || (clk_en && wdog_hit)) begin
			mode_r    <= gtsw_pkg::GTSW_POWERUP;
			cnt_r     <= '0;
			wdog_r    <= '0;
			step_r    <= '0;
			peaks_r   <= '0;
			out_r     <= 1'b1;
			gain_r    <= GW'(`GTSW_GAIN_RST);
			last_hi_r <= MID;
			last_lo_r <= MID;
			prev_r    <= MID;
		end else if (clk_en) begin
			if (sample_vld)
				prev_r <= sig;
			case (mode_r)
				gtsw_pkg::GTSW_POWERUP: begin
					// Output held high until the front end has settled
					cnt_r <= cnt_r + 32'd1;
					if (cnt_r >= 32'(PU_CYC - 1))
						mode_r <= gtsw_pkg::GTSW_STARTUP;
				end
				gtsw_pkg::GTSW_STARTUP: begin
					if (sample_vld && start_ok) begin
						mode_r    <= gtsw_pkg::GTSW_CAL;
						last_hi_r <= pk_hi;
						last_lo_r <= pk_lo;
						// Threshold counts as already passed; only low side moves it
						if (hi_side)
							out_r <= 1'b1;
						else
							out_r <= 1'b0;
					end
				end
				gtsw_pkg::GTSW_CAL: begin
					if (edge_evt && op_x && !out_r) begin
						// Gain steps down by one, not below the minimum, on each rising edge whose peak lies above half the optimum level
						peaks_r <= peaks_r + 8'd1;
						if (pk_hi - MID > (OPT >> 1) && gain_r > `GTSW_GAIN_MIN)
							gain_r <= gain_r - GW'(1);
						if (peaks_r >= 8'(CAL_PEAKS - 1))
							mode_r <= gtsw_pkg::GTSW_RUN;
					end
				end
				gtsw_pkg::GTSW_RUN: begin
					// Slow downward gain steps only, so edges are not disturbed
					if (sig_abs > OVR >> 1 && gain_r > `GTSW_GAIN_MIN) begin
						if (step_r == 16'(`GTSW_GAIN_STEP_CYC - 1)) begin
							step_r <= '0;
							gain_r <= gain_r - GW'(1);
						end else begin
							step_r <= step_r + 16'd1;
						end
					end else begin
						step_r <= '0;
					end
				end
				default: mode_r <= gtsw_pkg::GTSW_POWERUP;
			endcase
			if (switching && sample_vld) begin
				// Edge peaks feed the next threshold
				if (!rising && prev_r > thr && prev_r > last_lo_r)
					last_hi_r <= prev_r;
				if (rising && prev_r < thr && prev_r < last_hi_r)
					last_lo_r <= prev_r;
			end
			if (edge_evt) begin
				out_r  <= op_x;
				wdog_r <= '0;
			end else if (switching) begin
				wdog_r <= wdog_r + 32'd1;
			end
		end
	end

	// Offset follows the slow average of the raw signal's deviation from mid-scale
	always_ff @(posedge sys_clk) begin
		if (srst)
			ofs_r <= '0;
		else if (clk_en && sample_vld)
			ofs_r <= ofs_r + W'($signed(processed_field_signal - MID - ofs_r)
				>>> `GTSW_OFS_SHIFT);
	end

	assign supply_current_output = out_r | undervoltage_level;
	assign gain                  = gain_r;
	assign offset_tracker        = ofs_r;
	assign mode                  = mode_r;
	assign vib_blank             = vib;
endmodule

// ### test/gtsw_switch_logic_asserts.sv
// Assertion checker of the gear tooth switch logic
`timescale 1ns/1ps
module gtsw_switch_logic_chk (
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic       clk_en,
	input wire logic       undervoltage_level,
	input wire logic       supply_current_output,
	input wire logic [3:0] gain,
	input wire logic [2:0] mode,
	input wire logic       vib_blank
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	AST_UV_HIGH: assert property (undervoltage_level |-> supply_current_output)
		else $error("output low under undervoltage");
	AST_RST_STATE: assert property ($fell(srst) |-> supply_current_output && mode == 3'h0 && gain == 4'hf)
		else $error("bad state after reset");
	AST_PWRUP_HIGH: assert property (mode == 3'h0 |-> supply_current_output)
		else $error("output low in power-up");
	AST_START_HIGH: assert property (mode == 3'h1 |-> supply_current_output)
		else $error("output switched before threshold");
	AST_START_NEXT: assert property (mode == 3'h1 |=> mode inside {3'h1, 3'h2})
		else $error("bad mode after startup");
	AST_FREEZE: assert property (!clk_en |=> $stable(mode) && $stable(gain))
		else $error("state moved while disabled");
	AST_VIB_RUN: assert property (vib_blank |-> mode == 3'h3)
		else $error("blanking outside running mode");
	AST_VIB_HOLD: assert property (vib_blank && !undervoltage_level |=>
		undervoltage_level || mode != 3'h3 || $stable(supply_current_output))
		else $error("output switched while blanked");
	AST_GAIN_DOWN: assert property (mode == 3'h3 |=> mode != 3'h3 || gain <= $past(gain))
		else $error("gain rose in running mode");
	AST_GAIN_FLOOR: assert property (gain >= 4'h1)
		else $error("gain below floor");
endmodule
bind gtsw_switch_logic gtsw_switch_logic_chk chk_u (.sys_clk(sys_clk), .srst(srst),
	.clk_en(clk_en), .undervoltage_level(undervoltage_level),
	.supply_current_output(supply_current_output), .gain(gain), .mode(mode),
	.vib_blank(vib_blank));

// ### test/gtsw_ctrl_model.sv
// Controller model counting entries into the low current state
`timescale 1ns/1ps
module gtsw_ctrl_model (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       supply_current_output,
	output logic      [3:0] n_low
);
	logic prev_r;
	always_ff @(posedge sys_clk) begin
		prev_r <= supply_current_output;
		if (srst)
			n_low <= 4'h0;
		else if (prev_r && !supply_current_output)
			n_low <= n_low + 4'h1;
	end
endmodule

// ### test/gtsw_switch_logic_tb.sv
// Testbench of the gear tooth switch logic
`timescale 1ns/1ps
module gtsw_switch_logic_tb;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        clk_en = 1'b1;
	logic [11:0] pfs = 12'h800;
	logic        uv = 1'b0;
	logic        out;
	logic [3:0]  gain;
	logic [2:0]  mode;
	logic [3:0]  n_low;
	int          failures = 0;
	int          n_compared = 0;
	always #2.5 sys_clk = ~sys_clk;
	gtsw_switch_logic #(.WDOG_CYC(200)) dut_u (.sys_clk(sys_clk), .srst(srst),
		.clk_en(clk_en), .sample_vld(1'b1), .processed_field_signal(pfs),
		.undervoltage_level(uv), .supply_current_output(out), .gain(gain),
		.offset_tracker(), .mode(mode), .vib_blank());
	gtsw_ctrl_model ctrl_u (.sys_clk(sys_clk), .srst(srst),
		.supply_current_output(out), .n_low(n_low));
	task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(logic [11:0] v, int n);
		@(posedge sys_clk);
		pfs <= v;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_powerup;
		put(12'h800, 190);
		check("mode", {1'b0, mode}, 4'h0);
		check("out", {3'h0, out}, 4'h1);
		put(12'h800, 15);
		check("mode", {1'b0, mode}, 4'h1);
	endtask
	task automatic t_high_start;
		put(12'h7d0, 2);
		put(12'h830, 2);
		check("mode", {1'b0, mode}, 4'h1);
		put(12'ha00, 2);
		check("mode", {1'b0, mode}, 4'h2);
		check("out", {3'h0, out}, 4'h1);
		put(12'h600, 2);
		check("out", {3'h0, out}, 4'h0);
		repeat (3) begin
			put(12'ha00, 2);
			check("out", {3'h0, out}, 4'h1);
			put(12'h600, 2);
		end
		check("mode", {1'b0, mode}, 4'h3);
		check("gain", gain, 4'hf);
		put(12'ha00, 2);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		put(12'h600, 4);
		check("out", {3'h0, out}, 4'h1);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		put(12'h600, 2);
		check("out", {3'h0, out}, 4'h0);
		check("low count", n_low, 4'h5);
		@(posedge sys_clk);
		uv <= 1'b1;
		put(12'ha00, 2);
		put(12'h600, 2);
		check("out", {3'h0, out}, 4'h1);
		@(posedge sys_clk);
		uv <= 1'b0;
	endtask
	task automatic t_low_start;
		@(posedge sys_clk);
		srst <= 1'b1;
		put(12'h800, 6);
		@(posedge sys_clk);
		srst <= 1'b0;
		t_powerup();
		put(12'h830, 2);
		put(12'h7d0, 2);
		put(12'h600, 2);
		check("mode", {1'b0, mode}, 4'h2);
		check("out", {3'h0, out}, 4'h0);
		// Back to mid-scale: one rising crossing, then no edge, so only the watchdog can act
		put(12'h800, 210);
		check("mode", {1'b0, mode}, 4'h0);
		check("out", {3'h0, out}, 4'h1);
	endtask
	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		t_powerup();
		t_high_start();
		t_low_start();
		summarize();
	end
	initial begin
		#50us;
		failures++;
		summarize();
	end
endmodule
